// ### bench/alr_seq_sva.sv
`timescale 1ns/100ps
module alr_seq_chk (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [1:0] port_ack_pair_i,
   input wire logic grant_out_o,
   input wire logic done_o,
   input wire logic cache_miss_force_o,
   input wire logic burst_fill_block_o,
   input alr_pkg::alr_bus_type bus_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   property p_no_grant; bus_o.lock |-> !grant_out_o; endproperty
   a_no_grant: assert property (p_no_grant)
      else $error("grant in lock");
   property p_lock; bus_o.external_cycle_start || bus_o.as_s |->
      bus_o.lock && cache_miss_force_o && burst_fill_block_o; endproperty
   a_lock: assert property (p_lock)
      else $error("lock low");
   property p_rd_start; $rose(bus_o.external_cycle_start) && bus_o.rw_rd |->
      bus_o.operand_cycle_start && bus_o.lock && !bus_o.as_s && !bus_o.doe; endproperty
   a_rd_start: assert property (p_rd_start)
      else $error("bad read start");
   property p_strobe; $rose(bus_o.external_cycle_start) |=> bus_o.as_s && !bus_o.external_cycle_start &&
      !bus_o.operand_cycle_start && (bus_o.rw_rd ? bus_o.ds_s : !bus_o.ds_s && bus_o.dbg);
   endproperty
   a_strobe: assert property (p_strobe)
      else $error("bad strobe");
   property p_rd_ack; $rose(bus_o.as_s) && bus_o.rw_rd ##1
      port_ack_pair_i != 2'h0 |-> bus_o.dbg ##1 bus_o.as_s [*2] ##1
      !bus_o.as_s && !bus_o.ds_s && !bus_o.dbg; endproperty
   a_rd_ack: assert property (p_rd_ack)
      else $error("bad read end");
   property p_rd_wait; $rose(bus_o.as_s) && bus_o.rw_rd ##1
      port_ack_pair_i == 2'h0 |=> bus_o.as_s [*3]; endproperty
   a_rd_wait: assert property (p_rd_wait)
      else $error("no wait");
   property p_wr_setup; $rose(bus_o.external_cycle_start) && !bus_o.rw_rd |-> bus_o.operand_cycle_start &&
      $past(bus_o.lock) && !bus_o.doe ##1 !bus_o.doe ##1 bus_o.doe;
   endproperty
   a_wr_setup: assert property (p_wr_setup)
      else $error("bad write start");
   property p_wr_ack; $rose(bus_o.doe) && port_ack_pair_i != 2'h0 |=>
      bus_o.ds_s [*2] ##1 !bus_o.ds_s && !bus_o.as_s && bus_o.doe;
   endproperty
   a_wr_ack: assert property (p_wr_ack)
      else $error("bad write end");
   property p_hold; $fell(bus_o.as_s) |-> $stable(bus_o.addr) &&
      $stable(bus_o.space) && $stable(bus_o.rw_rd); endproperty
   a_hold: assert property (p_hold)
      else $error("address moved");
   property p_done; done_o |-> !bus_o.lock && $past(bus_o.lock); endproperty
   a_done: assert property (p_done)
      else $error("bad release");
endmodule
bind alr_seq alr_seq_chk alr_seq_chk_i (.ref_clk_i, .srst_i,
   .port_ack_pair_i, .grant_out_o, .done_o, .cache_miss_force_o,
   .burst_fill_block_o, .bus_o);

// ### bench/alr_seq_tb_top.sv
`timescale 1ns/100ps
module alr_seq_tb_top;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic cmd_valid = 1'b0;
   logic mod_valid = 1'b0;
   logic request = 1'b0;
   logic refuse = 1'b0;
   logic [3:0] dly = 4'h0;
   alr_pkg::alr_cmd_type cmd = '0;
   alr_pkg::alr_mod_type mod = '0;
   alr_pkg::alr_cap_state_type rd;
   alr_pkg::alr_bus_type bus;
   logic ready, rd_done, done, grant, miss, noburst, refuse_in;
   logic [1:0] ack;
   logic [31:0] rdata, wdata;
   int errors = 0;
   int checks_done = 0;
   always #12.5 clk = ~clk;
   alr_seq alr_seq_i (.ref_clk_i(clk), .srst_i(srst),
      .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_ready_o(ready),
      .rd_done_o(rd_done), .rd_o(rd), .mod_valid_i(mod_valid),
      .mod_i(mod), .done_o(done), .port_ack_pair_i(ack), .data_i(rdata),
      .cache_refuse_in_i(refuse_in), .request_in_i(request),
      .grant_out_o(grant), .bus_o(bus), .cache_miss_force_o(miss),
      .burst_fill_block_o(noburst));
   alr_slave_model alr_slave_model_i (.ref_clk_i(clk), .bus_i(bus),
      .ack_dly_i(dly), .refuse_i(refuse), .port_ack_pair_o(ack),
      .data_o(rdata), .cache_refuse_in_o(refuse_in), .wr_data_o(wdata));
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got 0x%h expected 0x%h", $time, got, exp);
      end
   endtask
   // w: 0 read done, 1 sequence done, 2 grant
   task automatic wait_for(input int w, output int n);
      n = 0;
      while ((w == 0 ? rd_done : w == 1 ? done : grant) !== 1'b1 && n < 99)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if ((w == 0 ? rd_done : w == 1 ? done : grant) !== 1'b1) begin
         errors++;
         $display("Error at %0t: wait 0x%h gave up 0x%h", $time, w, n);
         end_of_test();
      end
   endtask
   task automatic seq(input alr_pkg::alr_op_type op, input logic two,
         input logic [1:0] nwr, input logic req);
      int n;
      cmd.op = op;
      cmd.two_rd = two;
      cmd_valid = 1'b1;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      request = req;
      wait_for(0, n);
      chk(rd.rd0, ~cmd.addr0);
      if (two) chk(rd.rd1, ~cmd.addr1);
      chk(rd.cacheable, !refuse && op != alr_pkg::ALR_OP_WALK);
      chk(bus.space, op == alr_pkg::ALR_OP_WALK ?
         alr_pkg::SPACE_SUP_DATA : cmd.space);
      chk(bus.addr, two ? cmd.addr1 : cmd.addr0);
      chk({bus.size, bus.inhibit}, {cmd.size, cmd.inhibit});
      chk({bus.lock, bus.rw_rd, bus.doe, bus.as_s}, 4'hc);
      mod.nwr = nwr;
      mod_valid = 1'b1;
      @(posedge clk);
      #1;
      mod_valid = 1'b0;
      wait_for(1, n);
      if (nwr == 2'h0) chk(n < 2, 1'b1);
      else chk(wdata, nwr == 2'h2 ? mod.wdata1 : mod.wdata0);
      chk({bus.lock, miss, noburst}, 3'h0);
      chk(bus.inhibit, nwr == 2'h0 ? cmd.inhibit : mod.inhibit);
      chk(bus.addr, nwr == 2'h2 ? mod.waddr1 : nwr == 2'h1 ? mod.waddr0 :
         two ? cmd.addr1 : cmd.addr0);
   endtask
   task automatic t_tas;
      int n;
      seq(alr_pkg::ALR_OP_TAS, 1'b0, 2'h1, 1'b1);
      wait_for(2, n);
      // a pending grant must keep the next command out
      cmd_valid = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk({bus.lock, bus.external_cycle_start, grant}, 3'h1);
      cmd_valid = 1'b0;
      request = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      $display("test tas ended");
   endtask
   task automatic t_cas_skip;
      dly = 4'h3;
      refuse = 1'b1;
      seq(alr_pkg::ALR_OP_CAS, 1'b0, 2'h0, 1'b0);
      refuse = 1'b0;
      $display("test cas ended");
   endtask
   task automatic t_dual_compare_swap_op;
      dly = 4'h2;
      seq(alr_pkg::ALR_OP_DUAL_COMPARE_SWAP_OP, 1'b1, 2'h2, 1'b1);
      request = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      $display("test dual_compare_swap_op ended");
   endtask
   task automatic t_walk;
      dly = 4'h1;
      seq(alr_pkg::ALR_OP_WALK, 1'b0, 2'h1, 1'b0);
      $display("test walk ended");
   endtask
   initial begin
      cmd.addr0 = 32'h0000_1004;
      cmd.addr1 = 32'h0000_2008;
      cmd.size = 2'h2;
      cmd.space = 3'h1;
      // inhibit differs between read and write so the swap is visible
      cmd.inhibit = 1'b1;
      mod.waddr0 = 32'h0000_3000;
      mod.waddr1 = 32'h0000_2008;
      mod.wdata0 = 32'h5a5a_0001;
      mod.wdata1 = 32'ha5a5_0002;
      repeat (6) @(posedge clk);
      #1;
      srst = 1'b0;
      chk({ready, grant, bus.lock, bus.rw_rd}, 4'h9);
      t_tas();
      t_cas_skip();
      t_dual_compare_swap_op();
      t_walk();
      end_of_test();
   end
endmodule

// ### bench/alr_slave_model.sv
`timescale 1ns/100ps
module alr_slave_model (
   input wire logic ref_clk_i,
   input alr_pkg::alr_bus_type bus_i,
   input wire logic [3:0] ack_dly_i,
   input wire logic refuse_i,
   output logic [1:0] port_ack_pair_o,
   output logic [31:0] data_o,
   output logic cache_refuse_in_o,
   output logic [31:0] wr_data_o
);
   logic [3:0] cnt_r = 4'h0;
   initial begin
      port_ack_pair_o = 2'h0;
      data_o = 32'h0;
      cache_refuse_in_o = 1'b0;
      wr_data_o = 32'h0;
   end
   // released data toggles so a stale word is never read as valid
   always @(posedge ref_clk_i) begin
      #1;
      if (bus_i.as_s && bus_i.ds_s && !bus_i.rw_rd)
         wr_data_o = bus_i.dout;
      if (bus_i.as_s && cnt_r >= ack_dly_i)
         port_ack_pair_o = ack_dly_i[0] ? 2'h1 : 2'h2;
      else
         port_ack_pair_o = 2'h0;
      data_o = (bus_i.as_s && bus_i.rw_rd) ? ~bus_i.addr : ~data_o;
      cache_refuse_in_o = refuse_i && bus_i.as_s;
      cnt_r = bus_i.as_s ? cnt_r + 4'h1 : 4'h0;
   end
endmodule

// ### rtl/alr_grant.sv
`timescale 1ns/100ps
module alr_grant (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic request_in_i,
   input wire logic busy_nxt_i,
   output logic grant_out_o
);
   logic grant_r;
   logic grant_nxt;

   // busy is the sequencer's next state, so grant drops on the same
   // edge the lock rises and returns on the same edge the lock falls
   always_comb begin
      grant_nxt = request_in_i && !busy_nxt_i;
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         grant_r <= 1'b0;
      end else begin
         grant_r <= grant_nxt;
      end
   end

   assign grant_out_o = grant_r;
endmodule

// ### rtl/alr_pkg.sv
package alr_pkg;
   // one ref_clk cycle is one half-clock bus state
   localparam int CLK_PERIOD_NS = 25;
   localparam int STATE_NS = 25;
   localparam int WAIT_NS = 50;
   localparam int STATE_CYC = (STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAIT_CYC = (WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] WAIT_LAST = 2'(WAIT_CYC - 1);
   localparam logic [2:0] SPACE_SUP_DATA = 3'h5;
   localparam logic DIR_READ = 1'b1;
   localparam logic [1:0] NWR_NONE = 2'h0;
   localparam logic [1:0] NWR_TWO = 2'h2;

   typedef enum logic [1:0] {
      ALR_OP_TAS = 2'h0,
      ALR_OP_CAS = 2'h1,
      ALR_OP_DUAL_COMPARE_SWAP_OP = 2'h2,
      ALR_OP_WALK = 2'h3
   } alr_op_type;

   typedef enum logic [15:0] {
      ALR_IDLE = 16'h0001,
      ALR_S0 = 16'h0002,
      ALR_S1 = 16'h0004,
      ALR_S2 = 16'h0008,
      ALR_S3 = 16'h0010,
      ALR_WRD = 16'h0020,
      ALR_S4 = 16'h0040,
      ALR_S5 = 16'h0080,
      ALR_MOD = 16'h0100,
      ALR_S6 = 16'h0200,
      ALR_S7 = 16'h0400,
      ALR_S8 = 16'h0800,
      ALR_S9 = 16'h1000,
      ALR_WWR = 16'h2000,
      ALR_S10 = 16'h4000,
      ALR_S11 = 16'h8000
   } alr_state_type;

   typedef struct packed {
      alr_op_type op;
      logic [31:0] addr0;
      logic [31:0] addr1;
      logic [1:0] size;
      logic [2:0] space;
      logic inhibit;
      logic two_rd;
   } alr_cmd_type;

   typedef struct packed {
      logic [1:0] nwr;
      logic inhibit;
      logic [31:0] waddr0;
      logic [31:0] waddr1;
      logic [31:0] wdata0;
      logic [31:0] wdata1;
   } alr_mod_type;

   typedef struct packed {
      logic [31:0] addr;
      logic [2:0] space;
      logic [1:0] size;
      logic rw_rd;
      logic inhibit;
      logic external_cycle_start;
      logic operand_cycle_start;
      logic as_s;
      logic ds_s;
      logic dbg;
      logic lock;
      logic [31:0] dout;
      logic doe;
   } alr_bus_type;

   typedef struct packed {
      alr_state_type st;
      alr_cmd_type cmd;
      alr_mod_type wr;
      logic idx;
      logic ackhit;
      logic [1:0] cnt;
      logic cmd_ready;
      logic rd_done;
      logic done;
      alr_bus_type bus;
   } alr_seq_state_type;

   typedef struct packed {
      logic [31:0] rd0;
      logic [31:0] rd1;
      logic cacheable;
   } alr_cap_state_type;
endpackage

// ### rtl/alr_rd_capture.sv
`timescale 1ns/100ps
module alr_rd_capture (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic take_i,
   input wire logic idx_i,
   input wire logic walk_i,
   input wire logic [31:0] data_i,
   input wire logic cache_refuse_in_i,
   output alr_pkg::alr_cap_state_type cap_o
);
   alr_pkg::alr_cap_state_type r;
   alr_pkg::alr_cap_state_type n;

   always_comb begin
      n = r;
      if (take_i) begin
         // refuse level and data taken in the single S4 cycle
         if (idx_i) begin
            n.rd1 = data_i;
         end else begin
            n.rd0 = data_i;
            n.cacheable = !cache_refuse_in_i && !walk_i;
         end
         if (idx_i && cache_refuse_in_i) begin
            n.cacheable = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign cap_o = r;
endmodule

// ### rtl/alr_seq.sv
`timescale 1ns/100ps
module alr_seq (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic cmd_valid_i,
   input alr_pkg::alr_cmd_type cmd_i,
   output logic cmd_ready_o,
   output logic rd_done_o,
   output alr_pkg::alr_cap_state_type rd_o,
   input wire logic mod_valid_i,
   input alr_pkg::alr_mod_type mod_i,
   output logic done_o,
   input wire logic [1:0] port_ack_pair_i,
   input wire logic [31:0] data_i,
   input wire logic cache_refuse_in_i,
   input wire logic request_in_i,
   output logic grant_out_o,
   output alr_pkg::alr_bus_type bus_o,
   output logic cache_miss_force_o,
   output logic burst_fill_block_o
);
   alr_pkg::alr_seq_state_type r;
   alr_pkg::alr_seq_state_type n;
   logic take;
   logic busy_nxt;
   logic walk;

   function automatic alr_pkg::alr_bus_type ctl(
      input alr_pkg::alr_state_type s,
      input alr_pkg::alr_bus_type b
   );
      alr_pkg::alr_bus_type o;
      o = b;
      o.lock = (s != alr_pkg::ALR_IDLE);
      o.external_cycle_start = (s == alr_pkg::ALR_S0) || (s == alr_pkg::ALR_S6);
      o.operand_cycle_start = o.external_cycle_start;
      // read direction held through the idle states to avoid a clash
      o.rw_rd = !((s == alr_pkg::ALR_S6) || (s == alr_pkg::ALR_S7) ||
         (s == alr_pkg::ALR_S8) || (s == alr_pkg::ALR_S9) ||
         (s == alr_pkg::ALR_WWR) || (s == alr_pkg::ALR_S10) ||
         (s == alr_pkg::ALR_S11));
      o.as_s = (s == alr_pkg::ALR_S1) || (s == alr_pkg::ALR_S2) ||
         (s == alr_pkg::ALR_S3) || (s == alr_pkg::ALR_WRD) ||
         (s == alr_pkg::ALR_S4) || (s == alr_pkg::ALR_S7) ||
         (s == alr_pkg::ALR_S8) || (s == alr_pkg::ALR_S9) ||
         (s == alr_pkg::ALR_WWR) || (s == alr_pkg::ALR_S10);
      o.ds_s = (s == alr_pkg::ALR_S1) || (s == alr_pkg::ALR_S2) ||
         (s == alr_pkg::ALR_S3) || (s == alr_pkg::ALR_WRD) ||
         (s == alr_pkg::ALR_S4) || (s == alr_pkg::ALR_S9) ||
         (s == alr_pkg::ALR_WWR) || (s == alr_pkg::ALR_S10);
      o.dbg = (s == alr_pkg::ALR_S2) || (s == alr_pkg::ALR_S3) ||
         (s == alr_pkg::ALR_WRD) || (s == alr_pkg::ALR_S4) ||
         (s == alr_pkg::ALR_S7) || (s == alr_pkg::ALR_S8) ||
         (s == alr_pkg::ALR_S9) || (s == alr_pkg::ALR_WWR) ||
         (s == alr_pkg::ALR_S10) || (s == alr_pkg::ALR_S11);
      o.doe = (s == alr_pkg::ALR_S8) || (s == alr_pkg::ALR_S9) ||
         (s == alr_pkg::ALR_WWR) || (s == alr_pkg::ALR_S10) ||
         (s == alr_pkg::ALR_S11);
      return o;
   endfunction

   function automatic logic [31:0] pick(
      input logic sel,
      input logic [31:0] a,
      input logic [31:0] b
   );
      return sel ? b : a;
   endfunction

   always_comb begin
      n = r;
      n.rd_done = 1'b0;
      n.done = 1'b0;
      take = 1'b0;
      unique case (r.st)
         alr_pkg::ALR_IDLE: begin
            // grant outstanding means another master owns the bus
            if (cmd_valid_i && !grant_out_o) begin
               n.cmd = cmd_i;
               if (cmd_i.op == alr_pkg::ALR_OP_WALK) begin
                  n.cmd.space = alr_pkg::SPACE_SUP_DATA;
               end
               n.idx = 1'b0;
               n.st = alr_pkg::ALR_S0;
            end
         end
         alr_pkg::ALR_S0: n.st = alr_pkg::ALR_S1;
         alr_pkg::ALR_S1: n.st = alr_pkg::ALR_S2;
         alr_pkg::ALR_S2: begin
            n.ackhit = |port_ack_pair_i;
            n.st = alr_pkg::ALR_S3;
         end
         alr_pkg::ALR_S3: begin
            n.cnt = 2'h0;
            n.st = r.ackhit ? alr_pkg::ALR_S4 : alr_pkg::ALR_WRD;
         end
         alr_pkg::ALR_WRD: begin
            // sample once per full clock, on the falling-edge slot
            n.cnt = r.cnt + 2'h1;
            if (r.cnt == alr_pkg::WAIT_LAST) begin
               n.cnt = 2'h0;
               if (|port_ack_pair_i) begin
                  n.st = alr_pkg::ALR_S4;
               end
            end
         end
         alr_pkg::ALR_S4: begin
            take = 1'b1;
            n.st = alr_pkg::ALR_S5;
         end
         alr_pkg::ALR_S5: begin
            if (!r.idx && r.cmd.two_rd) begin
               n.idx = 1'b1;
               n.st = alr_pkg::ALR_S0;
            end else begin
               n.idx = 1'b0;
               n.rd_done = 1'b1;
               n.st = alr_pkg::ALR_MOD;
            end
         end
         alr_pkg::ALR_MOD: begin
            if (mod_valid_i) begin
               n.wr = mod_i;
               if (mod_i.nwr == alr_pkg::NWR_NONE) begin
                  n.done = 1'b1;
                  n.st = alr_pkg::ALR_IDLE;
               end else begin
                  n.st = alr_pkg::ALR_S6;
               end
            end
         end
         alr_pkg::ALR_S6: n.st = alr_pkg::ALR_S7;
         alr_pkg::ALR_S7: n.st = alr_pkg::ALR_S8;
         alr_pkg::ALR_S8: begin
            n.ackhit = |port_ack_pair_i;
            n.st = alr_pkg::ALR_S9;
         end
         alr_pkg::ALR_S9: begin
            n.cnt = 2'h0;
            n.st = r.ackhit ? alr_pkg::ALR_S10 : alr_pkg::ALR_WWR;
         end
         alr_pkg::ALR_WWR: begin
            n.cnt = r.cnt + 2'h1;
            if (r.cnt == alr_pkg::WAIT_LAST) begin
               n.cnt = 2'h0;
               if (|port_ack_pair_i) begin
                  n.st = alr_pkg::ALR_S10;
               end
            end
         end
         alr_pkg::ALR_S10: n.st = alr_pkg::ALR_S11;
         alr_pkg::ALR_S11: begin
            if (!r.idx && (r.wr.nwr == alr_pkg::NWR_TWO)) begin
               n.idx = 1'b1;
               n.st = alr_pkg::ALR_S6;
            end else begin
               n.idx = 1'b0;
               n.done = 1'b1;
               n.st = alr_pkg::ALR_IDLE;
            end
         end
         default: begin
            n.st = alr_pkg::ALR_IDLE;
         end
      endcase

      // address, space and size only change at a cycle start
      if (n.st == alr_pkg::ALR_S0 && r.st != alr_pkg::ALR_S0) begin
         n.bus.addr = pick(n.idx, n.cmd.addr0, n.cmd.addr1);
         n.bus.space = n.cmd.space;
         n.bus.size = n.cmd.size;
         n.bus.inhibit = n.cmd.inhibit;
      end
      if (n.st == alr_pkg::ALR_S6 && r.st != alr_pkg::ALR_S6) begin
         n.bus.addr = pick(n.idx, n.wr.waddr0, n.wr.waddr1);
         n.bus.inhibit = n.wr.inhibit;
      end
      if (n.st == alr_pkg::ALR_S8 && r.st != alr_pkg::ALR_S8) begin
         n.bus.dout = pick(n.idx, n.wr.wdata0, n.wr.wdata1);
      end
      n.bus = ctl(n.st, n.bus);
      n.cmd_ready = (n.st == alr_pkg::ALR_IDLE);
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         r <= '0;
         r.st <= alr_pkg::ALR_IDLE;
         r.cmd_ready <= 1'b1;
         r.bus.rw_rd <= alr_pkg::DIR_READ;
      end else begin
         r <= n;
      end
   end

   assign busy_nxt = (n.st != alr_pkg::ALR_IDLE);
   assign walk = (r.cmd.op == alr_pkg::ALR_OP_WALK);

   alr_grant u_grant (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .request_in_i(request_in_i),
      .busy_nxt_i(busy_nxt),
      .grant_out_o(grant_out_o)
   );

   alr_rd_capture u_cap (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .take_i(take),
      .idx_i(r.idx),
      .walk_i(walk),
      .data_i(data_i),
      .cache_refuse_in_i(cache_refuse_in_i),
      .cap_o(rd_o)
   );

   assign cmd_ready_o = r.cmd_ready;
   assign rd_done_o = r.rd_done;
   assign done_o = r.done;
   assign bus_o = r.bus;
   // cache is bypassed and burst fill held off while locked
   assign cache_miss_force_o = r.bus.lock;
   assign burst_fill_block_o = r.bus.lock;
endmodule
